//--- src/wac_ctrl.sv
// Implementation choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Summary of operation
// - wait bit 0: transfer irq at eighth fall; master holds clock low
// - wait bit 0, slave: clock held low after eight received clocks
// - wait bit 1: transfer irq at ninth fall instead of eighth
// - wait bit 1, master: wait inserted at ninth fall of address byte
// - wait bit 1, addressed slave: acknowledge, then wait at ninth fall
// - wait bit 1, slave with extension code: wait at eighth fall
// - wait bit changes only by software write; reset clears it
// - acknowledge bit 1 drives data low during ninth clock; 0 drives none except for a matching address
// - acknowledge bit changes only by software write; reset clears it
// - address phase: matching slave always acknowledges; bit used for extension codes
// - wait and acknowledge bits have no effect while interface disabled
// - start trigger on free bus makes a start and becomes master
// - busy bus, reservation allowed: start held, issued once bus frees
// - busy bus, reservation disabled: trigger dropped, start-clear flag set
// - master in wait: start trigger releases wait, then repeated start
// - operation enable 0 stops engine and clears status; 1 runs it
// - reservation-disable at flag bit 0, start-clear flag at bit 7
// - start trigger clears after start, arbitration loss, disable, reset
// ****************************************
module wac_ctrl #(
   parameter int unsigned HALF_CYC = wac_pkg::HALF_CYCLES
) (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire wac_pkg::wac_bus_req_s bus_req_i,
   output logic [wac_pkg::DW-1:0] rdata_o,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic scl_o,
   output logic scl_oe_o,
   output logic sda_o,
   output logic sda_oe_o,
   output logic irq_o
);
   import wac_pkg::*;

   function automatic logic hit(input logic [AW-1:0] a, input logic [AW-1:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   logic scl_m_q, scl_s_q, scl_p_q, sda_m_q, sda_s_q, sda_p_q;
   logic en_q, wait_timing_sel_q, ack_drive_en_q, stt_q, rsv_q, start_clear_flag_q, busy_q;
   logic [6:0] own_q;
   logic [DW-1:0] sh_q, rdata_q, rd_val;
   logic [3:0] cnt_q;
   logic addr_q, mst_q, slv_q, ext_q, trc_q, wait_q, ackd_q;
   logic sda_low_q, scl_low_q, scl_oe_q, pin_q, irq_q;
   wac_mst_e st_q;
   logic [TW-1:0] tmr_q;
   logic [IRQ_W-1:0] sts_q, msk_q, ev;

   // ****************************************
   // register port decode
   // ****************************************
   logic wr_ctl, wr_flag, wr_data, wr_own, wr_sts, wr_msk;
   logic [DW-1:0] wd;
   assign wd = bus_req_i.wdata;
   assign wr_ctl = bus_req_i.wr & hit(bus_req_i.addr, OFS_CTL0);
   assign wr_flag = bus_req_i.wr & hit(bus_req_i.addr, OFS_FLAG);
   assign wr_data = bus_req_i.wr & hit(bus_req_i.addr, OFS_DATA);
   assign wr_own = bus_req_i.wr & hit(bus_req_i.addr, OFS_OWN);
   assign wr_sts = bus_req_i.wr & hit(bus_req_i.addr, OFS_ISTS);
   assign wr_msk = bus_req_i.wr & hit(bus_req_i.addr, OFS_IMSK);

   // ****************************************
   // line synchronisers and edge detection
   // ****************************************
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         scl_m_q <= 1'b1;
         scl_s_q <= 1'b1;
         scl_p_q <= 1'b1;
         sda_m_q <= 1'b1;
         sda_s_q <= 1'b1;
         sda_p_q <= 1'b1;
      end else begin
         scl_m_q <= scl_i;
         scl_s_q <= scl_m_q;
         scl_p_q <= scl_s_q;
         sda_m_q <= sda_i;
         sda_s_q <= sda_m_q;
         sda_p_q <= sda_s_q;
      end
   end

   logic rise, fall, start_det, stop_det;
   assign rise = en_q & scl_s_q & ~scl_p_q;
   assign fall = en_q & ~scl_s_q & scl_p_q;
   assign start_det = en_q & scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
   assign stop_det = en_q & scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;

   // ****************************************
   // byte position decisions
   // ****************************************
   logic data_rise, ack_rise, fall8, fall9, match_now, ext_now;
   logic slv_cur, ext_cur, inv8, inv, wait8, wait9, ack9, tx;
   logic arb_lost, mst_wait, stt_wr, stt_refuse, start_go;
   logic start_done, rs_go, rs_start, tmr_done;
   assign data_rise = rise & (cnt_q != CNT_8);
   assign ack_rise = rise & (cnt_q == CNT_8);
   assign fall8 = fall & (cnt_q == CNT_8);
   assign fall9 = fall & (cnt_q == CNT_9);
   assign match_now = (sh_q[7:1] == own_q);
   assign ext_now = (sh_q[7:4] == EXT_PREFIX);
   assign slv_cur = addr_q ? (~mst_q & match_now) : slv_q;
   assign ext_cur = addr_q ? (~mst_q & ext_now) : ext_q;
   assign inv8 = mst_q | slv_cur | ext_cur;
   assign inv = mst_q | slv_q | ext_q;
   // disabled engine never reaches these, so the two bits are inert then
   assign wait8 = fall8 & inv8 & (~wait_timing_sel_q | ext_cur);
   assign wait9 = fall9 & inv & wait_timing_sel_q & ~ext_q;
   // matching slave acks whatever the bit says
   assign ack9 = addr_q ? (slv_cur | (ext_cur & ack_drive_en_q)) : (~trc_q & inv & ack_drive_en_q);
   assign tx = trc_q & inv;
   assign arb_lost = data_rise & mst_q & trc_q & ~sda_low_q & ~sda_s_q;
   assign mst_wait = mst_q & wait_q;
   assign stt_wr = wr_ctl & wd[B_STT] & en_q;
   assign stt_refuse = stt_wr & busy_q & rsv_q & ~mst_wait;
   assign start_go = (st_q == M_IDLE) & stt_q & ~busy_q & en_q;
   assign tmr_done = (tmr_q == TW'(HALF_CYC - 1));
   assign start_done = (st_q == M_START) & tmr_done;
   assign rs_go = (st_q == M_RUN) & wait_q & stt_q;
   assign rs_start = (st_q == M_RS2) & scl_s_q & tmr_done;

   // ****************************************
   // software control bits
   // ****************************************
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         en_q <= 1'b0;
         wait_timing_sel_q <= 1'b0;
         ack_drive_en_q <= 1'b0;
      end else if (wr_ctl) begin
         en_q <= wd[B_OPEN];
         wait_timing_sel_q <= wd[B_WAIT_TIMING_SEL];
         ack_drive_en_q <= wd[B_ACK_DRIVE_EN];
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         rsv_q <= 1'b0;
         own_q <= OWN_RST;
         msk_q <= '0;
      end else begin
         if (wr_flag) begin
            rsv_q <= wd[B_RSVD];
         end
         if (wr_own) begin
            own_q <= wd[7:1];
         end
         if (wr_msk) begin
            msk_q <= wd[IRQ_W-1:0];
         end
      end
   end

   // start trigger: set by write, cleared by the engine
   always_ff @(posedge clk_i) begin
      if (srst_i || !en_q) begin
         stt_q <= 1'b0;
      end else if (stt_wr && !stt_refuse) begin
         stt_q <= 1'b1;
      end else if (stt_refuse || start_done || arb_lost) begin
         // a refused trigger also drops a reservation that was still pending
         stt_q <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i || !en_q) begin
         start_clear_flag_q <= 1'b0;
      end else if (stt_refuse) begin
         start_clear_flag_q <= 1'b1;
      end else if (start_go) begin
         start_clear_flag_q <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i || !en_q) begin
         busy_q <= 1'b0;
      end else if (start_det) begin
         busy_q <= 1'b1;
      end else if (stop_det) begin
         busy_q <= 1'b0;
      end
   end

   // ****************************************
   // bus monitor: bit count and roles
   // ****************************************
   always_ff @(posedge clk_i) begin
      if (srst_i || !en_q || stop_det) begin
         cnt_q <= CNT_ZERO;
         addr_q <= 1'b0;
         slv_q <= 1'b0;
         ext_q <= 1'b0;
         trc_q <= 1'b0;
      end else if (start_det) begin
         cnt_q <= CNT_ZERO;
         addr_q <= 1'b1;
         slv_q <= 1'b0;
         ext_q <= 1'b0;
         trc_q <= mst_q;
      end else begin
         if (rise) begin
            cnt_q <= (cnt_q == CNT_9) ? CNT_ONE : cnt_q + CNT_ONE;
         end
         if (fall8 && addr_q) begin
            slv_q <= slv_cur;
            ext_q <= ext_cur;
            trc_q <= mst_q ? ~sh_q[0] : sh_q[0];
         end
         if (fall9) begin
            addr_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i || !en_q) begin
         ackd_q <= 1'b0;
      end else if (ack_rise) begin
         ackd_q <= ~sda_s_q;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         sh_q <= '0;
      end else if (wr_data) begin
         sh_q <= wd;
      end else if (data_rise) begin
         sh_q <= {sh_q[6:0], sda_s_q};
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i || !en_q || stop_det || arb_lost) begin
         mst_q <= 1'b0;
      end else if (start_go) begin
         mst_q <= 1'b1;
      end
   end

   // ****************************************
   // wait: clock held low
   // ****************************************
   always_ff @(posedge clk_i) begin
      if (srst_i || !en_q || stop_det) begin
         wait_q <= 1'b0;
      end else if (wait8 || wait9 || start_done) begin
         wait_q <= 1'b1;
      end else if (wr_data || rs_go) begin
         wait_q <= 1'b0;
      end
   end

   // ****************************************
   // master clock and start generator
   // ****************************************
   always_ff @(posedge clk_i) begin
      if (srst_i || !en_q || arb_lost || stop_det) begin
         st_q <= M_IDLE;
         scl_low_q <= 1'b0;
         tmr_q <= '0;
      end else begin
         case (st_q)
            M_IDLE: begin
               tmr_q <= '0;
               if (start_go) begin
                  st_q <= M_START;
               end
            end
            M_START: begin
               tmr_q <= tmr_q + TW'(1);
               if (tmr_done) begin
                  scl_low_q <= 1'b1;
                  st_q <= M_RUN;
                  tmr_q <= '0;
               end
            end
            M_RUN: begin
               if (rs_go) begin
                  st_q <= M_RS1;
                  scl_low_q <= 1'b1;
                  tmr_q <= '0;
               end else if (wait_q) begin
                  scl_low_q <= 1'b1;
                  tmr_q <= '0;
               end else if (scl_low_q || scl_s_q) begin
                  tmr_q <= tmr_q + TW'(1);
                  if (tmr_done) begin
                     scl_low_q <= ~scl_low_q;
                     tmr_q <= '0;
                  end
               end
            end
            M_RS1: begin
               tmr_q <= tmr_q + TW'(1);
               if (tmr_done) begin
                  scl_low_q <= 1'b0;
                  st_q <= M_RS2;
                  tmr_q <= '0;
               end
            end
            M_RS2: begin
               if (scl_s_q) begin
                  tmr_q <= tmr_q + TW'(1);
               end
               if (rs_start) begin
                  st_q <= M_START;
                  tmr_q <= '0;
               end
            end
            default: begin
               st_q <= M_IDLE;
            end
         endcase
      end
   end

   // ****************************************
   // data line drive
   // ****************************************
   always_ff @(posedge clk_i) begin
      if (srst_i || !en_q || arb_lost || stop_det) begin
         sda_low_q <= 1'b0;
      end else if (start_go || rs_start) begin
         sda_low_q <= 1'b1;
      end else if (rs_go) begin
         sda_low_q <= 1'b0;
      end else if (fall) begin
         // ninth bit: ack or release, other bits: transmit data
         sda_low_q <= (cnt_q == CNT_8) ? ack9 : (tx & ~sh_q[7]);
      end else if (wr_data && cnt_q != CNT_8) begin
         sda_low_q <= tx & ~wd[7];
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         scl_oe_q <= 1'b0;
         pin_q <= 1'b0;
      end else begin
         scl_oe_q <= en_q & (wait_q | scl_low_q);
         pin_q <= 1'b0;
      end
   end

   // ****************************************
   // interrupt status and mask
   // ****************************************
   assign ev[I_XFER] = wait8 | wait9;
   assign ev[I_START_CLEAR_FLAG] = stt_refuse;
   assign ev[I_STOP] = stop_det;

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         sts_q <= '0;
         irq_q <= 1'b0;
      end else begin
         sts_q <= (sts_q & ~(wr_sts ? wd[IRQ_W-1:0] : '0)) | ev;
         irq_q <= |(sts_q & msk_q);
      end
   end

   // ****************************************
   // read port
   // ****************************************
   always_comb begin
      rd_val = '0;
      case (bus_req_i.addr)
         OFS_CTL0: begin
            rd_val[B_OPEN] = en_q;
            rd_val[B_WAIT_TIMING_SEL] = wait_timing_sel_q;
            rd_val[B_ACK_DRIVE_EN] = ack_drive_en_q;
            rd_val[B_STT] = stt_q;
         end
         OFS_FLAG: begin
            rd_val[B_START_CLEAR_FLAG] = start_clear_flag_q;
            rd_val[B_BUSY] = busy_q;
            rd_val[B_RSVD] = rsv_q;
         end
         OFS_DATA: rd_val = sh_q;
         OFS_OWN: rd_val = {own_q, 1'b0};
         OFS_STAT: begin
            rd_val[B_MST] = mst_q;
            rd_val[B_SLV] = slv_q;
            rd_val[B_EXT] = ext_q;
            rd_val[B_TRC] = trc_q;
            rd_val[B_WAIT] = wait_q;
            rd_val[B_ACKD] = ackd_q;
         end
         OFS_ISTS: rd_val[IRQ_W-1:0] = sts_q;
         OFS_IMSK: rd_val[IRQ_W-1:0] = msk_q;
         default: rd_val = '0;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         rdata_q <= '0;
      end else begin
         rdata_q <= bus_req_i.rd ? rd_val : '0;
      end
   end

   assign rdata_o = rdata_q;
   assign scl_oe_o = scl_oe_q;
   assign sda_oe_o = sda_low_q;
   assign scl_o = pin_q;
   assign sda_o = pin_q;
   assign irq_o = irq_q;

   // ****************************************
   // checks
   // ****************************************
   sequence s_go;
      start_go;
   endsequence
   sequence s_start_out;
      sda_oe_o ##1 (st_q == M_START);
   endsequence

   property p_start;
      @(posedge clk_i) disable iff (srst_i) s_go |=> s_start_out;
   endproperty
   a_start: assert property (p_start) else $error("no start after trigger");

   property p_wait0;
      @(posedge clk_i) disable iff (srst_i) (fall8 && inv8 && !wait_timing_sel_q) |=> wait_q ##1 scl_oe_o;
   endproperty
   a_wait0: assert property (p_wait0) else $error("no wait at eighth fall");

   property p_irq1;
      @(posedge clk_i) disable iff (srst_i) (fall9 && inv && wait_timing_sel_q && !ext_q) |=> sts_q[I_XFER];
   endproperty
   a_irq1: assert property (p_irq1) else $error("no irq at ninth fall");

   property p_no8;
      @(posedge clk_i) disable iff (srst_i)
         (fall8 && wait_timing_sel_q && !ext_cur && !wait_q && !start_done) |=> !wait_q;
   endproperty
   a_no8: assert property (p_no8) else $error("wait at eighth fall with bit set");

   property p_ext8;
      @(posedge clk_i) disable iff (srst_i) (fall8 && addr_q && !mst_q && ext_now) |=> wait_q;
   endproperty
   a_ext8: assert property (p_ext8) else $error("no wait for extension code");

   property p_match_ack;
      @(posedge clk_i) disable iff (srst_i) (fall8 && addr_q && !mst_q && match_now) |=> sda_oe_o;
   endproperty
   a_match_ack: assert property (p_match_ack) else $error("matched slave did not ack");

   property p_nack;
      @(posedge clk_i) disable iff (srst_i) (fall8 && !addr_q && !ack_drive_en_q) |=> !sda_oe_o;
   endproperty
   a_nack: assert property (p_nack) else $error("ack driven while disabled");

   property p_refuse;
      @(posedge clk_i) disable iff (srst_i) stt_refuse |=> (!stt_q && start_clear_flag_q);
   endproperty
   a_refuse: assert property (p_refuse) else $error("refused trigger not flagged");

   property p_off;
      @(posedge clk_i) disable iff (srst_i) !en_q |=> (!stt_q && !busy_q && !start_clear_flag_q && !wait_q);
   endproperty
   a_off: assert property (p_off) else $error("state kept while disabled");

   property p_restart;
      @(posedge clk_i) disable iff (srst_i) rs_go |=> (!wait_q && !sda_oe_o && st_q == M_RS1);
   endproperty
   a_restart: assert property (p_restart) else $error("restart did not release");
endmodule : wac_ctrl
`default_nettype wire

//--- src/wac_pkg.sv
`default_nettype none
// ****************************************
// shared constants and types
// ****************************************
package wac_pkg;
   localparam int unsigned DW = 8;
   localparam int unsigned AW = 8;
   localparam int unsigned TW = 12;
   localparam int unsigned IRQ_W = 3;

   // register byte addresses
   localparam logic [7:0] OFS_CTL0 = 8'h00;
   localparam logic [7:0] OFS_FLAG = 8'h04;
   localparam logic [7:0] OFS_DATA = 8'h08;
   localparam logic [7:0] OFS_OWN = 8'h0C;
   localparam logic [7:0] OFS_STAT = 8'h10;
   localparam logic [7:0] OFS_ISTS = 8'h14;
   localparam logic [7:0] OFS_IMSK = 8'h18;

   // control register 0 fields
   localparam int unsigned B_OPEN = 7;
   localparam int unsigned B_WAIT_TIMING_SEL = 3;
   localparam int unsigned B_ACK_DRIVE_EN = 2;
   localparam int unsigned B_STT = 1;
   // flag register fields
   localparam int unsigned B_START_CLEAR_FLAG = 7;
   localparam int unsigned B_BUSY = 6;
   localparam int unsigned B_RSVD = 0;
   // status register fields
   localparam int unsigned B_MST = 7;
   localparam int unsigned B_SLV = 6;
   localparam int unsigned B_EXT = 5;
   localparam int unsigned B_TRC = 4;
   localparam int unsigned B_WAIT = 3;
   localparam int unsigned B_ACKD = 2;
   // interrupt status fields
   localparam int unsigned I_XFER = 0;
   localparam int unsigned I_START_CLEAR_FLAG = 1;
   localparam int unsigned I_STOP = 2;

   localparam logic [3:0] CNT_ZERO = 4'h0;
   localparam logic [3:0] CNT_ONE = 4'h1;
   localparam logic [3:0] CNT_8 = 4'h8;
   localparam logic [3:0] CNT_9 = 4'h9;
   localparam logic [3:0] EXT_PREFIX = 4'hF;
   localparam logic [6:0] OWN_RST = 7'h00;

   localparam int unsigned CLK_PERIOD_NS = 100;
   localparam int unsigned T_HALF_NS = 5000;
   localparam int unsigned HALF_CYCLES = (T_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef struct packed {
      logic [AW-1:0] addr;
      logic [DW-1:0] wdata;
      logic wr;
      logic rd;
   } wac_bus_req_s;

   typedef enum logic [2:0] {M_IDLE, M_START, M_RUN, M_RS1, M_RS2} wac_mst_e;
endpackage : wac_pkg
`default_nettype wire

//--- tb/test_wac_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module test_wac_ctrl;
   import wac_pkg::*;
   logic clk_i = 1'b0;
   logic srst_i = 1'b1;
   wac_bus_req_s bus_req = '0;
   logic [7:0] rdata_o;
   logic scl, sda, d_scl_o, d_scl_oe, d_sda_o, d_sda_oe, f_scl_oe, f_sda_oe, irq_o;
   logic scl_p = 1'b1;
   logic sda_p = 1'b1;
   int starts = 0;
   int num_errors = 0;
   int compares = 0;
   int cycles = 0;
   int n;
   always #50 clk_i = ~clk_i;
   // open-drain lines with pull-ups
   assign scl = ~((d_scl_oe & ~d_scl_o) | f_scl_oe);
   assign sda = ~((d_sda_oe & ~d_sda_o) | f_sda_oe);
   wac_ctrl #(.HALF_CYC(4)) i_dut (.clk_i(clk_i), .srst_i(srst_i), .bus_req_i(bus_req), .rdata_o(rdata_o),
      .scl_i(scl), .sda_i(sda), .scl_o(d_scl_o), .scl_oe_o(d_scl_oe), .sda_o(d_sda_o),
      .sda_oe_o(d_sda_oe), .irq_o(irq_o));
   wac_far_master i_far (.clk_i(clk_i), .scl_i(scl), .sda_i(sda), .scl_oe_o(f_scl_oe), .sda_oe_o(f_sda_oe));
   // ****************************************
   // bus monitor and timeout
   // ****************************************
   always @(posedge clk_i) begin
      scl_p <= scl;
      sda_p <= sda;
      if (scl && scl_p && sda_p && !sda) starts <= starts + 1;
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         num_errors++;
         summarize();
      end
   end
   // ****************************************
   // tasks
   // ****************************************
   task automatic tick(input int k);
      repeat (k) @(posedge clk_i);
   endtask : tick
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      compares++;
      if (g !== e) begin
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
         num_errors++;
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk_i);
      bus_req <= '0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
      @(posedge clk_i);
      bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk_i);
      bus_req <= '0;
      #1 chk(rdata_o & m, e);
   endtask : rd
   // one byte from the far master, wait checked after the eighth and ninth falls
   task automatic sbyte(input logic [7:0] b, input logic e8, input logic ack, input logic e9);
      logic r;
      for (int i = 7; i >= 0; i--) i_far.bit_io(b[i], r);
      tick(3);
      chk({7'h0, d_scl_oe}, {7'h0, e8});
      if (e8) wr(OFS_DATA, 8'h00);
      i_far.bit_io(1'b1, r);
      chk({7'h0, r}, {7'h0, ~ack});
      tick(3);
      chk({7'h0, d_scl_oe}, {7'h0, e9});
      if (e9) wr(OFS_DATA, 8'h00);
   endtask : sbyte
   task automatic wait_start(input int k);
      int t;
      t = 0;
      while (starts <= k && t < 200) begin
         tick(1);
         t++;
      end
      chk({7'h0, starts > k}, 8'h01);
   endtask : wait_start
   task automatic summarize();
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : summarize
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      tick(4);
      srst_i <= 1'b0;
      rd(OFS_CTL0, 8'h00, 8'hFF);
      rd(OFS_FLAG, 8'h00, 8'hFF);
      rd(8'h1C, 8'h00, 8'hFF);
      wr(OFS_CTL0, 8'h0E);
      rd(OFS_CTL0, 8'h0C, 8'hFF);
      wr(OFS_OWN, 8'hA0);
      i_far.start();
      sbyte(8'hA0, 1'b0, 1'b0, 1'b0);
      i_far.stop();
      wr(OFS_CTL0, 8'h00);
      wr(OFS_CTL0, 8'h80);
      wr(OFS_IMSK, 8'h01);
      wr(OFS_ISTS, 8'h07);
      i_far.start();
      sbyte(8'hA0, 1'b1, 1'b1, 1'b0);
      sbyte(8'h5A, 1'b1, 1'b0, 1'b0);
      rd(OFS_ISTS, 8'h01, 8'hFF);
      chk({7'h0, irq_o}, 8'h01);
      i_far.stop();
      rd(OFS_ISTS, 8'h05, 8'hFF);
      wr(OFS_ISTS, 8'h07);
      tick(2);
      chk({7'h0, irq_o}, 8'h00);
      wr(OFS_CTL0, 8'h0C);
      wr(OFS_CTL0, 8'h8C);
      i_far.start();
      sbyte(8'hA0, 1'b0, 1'b1, 1'b1);
      sbyte(8'h3C, 1'b0, 1'b1, 1'b1);
      i_far.stop();
      i_far.start();
      sbyte(8'hF0, 1'b1, 1'b1, 1'b0);
      i_far.stop();
      wr(OFS_CTL0, 8'h00);
      wr(OFS_CTL0, 8'h80);
      n = starts;
      wr(OFS_CTL0, 8'h82);
      wait_start(n);
      tick(10);
      rd(OFS_CTL0, 8'h80, 8'hFF);
      chk({7'h0, d_scl_oe}, 8'h01);
      rd(OFS_STAT, 8'h80, 8'h80);
      n = starts;
      wr(OFS_CTL0, 8'h82);
      wait_start(n);
      wr(OFS_CTL0, 8'h00);
      rd(OFS_STAT, 8'h00, 8'hFF);
      rd(OFS_CTL0, 8'h00, 8'hFF);
      wr(OFS_CTL0, 8'h80);
      wr(OFS_FLAG, 8'h01);
      wr(OFS_IMSK, 8'h02);
      i_far.start();
      wr(OFS_CTL0, 8'h82);
      rd(OFS_FLAG, 8'hC1, 8'hFF);
      rd(OFS_CTL0, 8'h80, 8'hFF);
      tick(2);
      chk({7'h0, irq_o}, 8'h01);
      wr(OFS_ISTS, 8'h02);
      tick(2);
      chk({7'h0, irq_o}, 8'h00);
      wr(OFS_FLAG, 8'h00);
      n = starts;
      wr(OFS_CTL0, 8'h82);
      tick(20);
      chk(8'(starts - n), 8'h00);
      i_far.stop();
      wait_start(n);
      wr(OFS_CTL0, 8'h00);
      tick(10);
      summarize();
   end
endmodule : test_wac_ctrl
`default_nettype wire

//--- tb/wac_far_master.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// far-side bus master, 800 ns link clock
// ****************************************
module wac_far_master (
   input wire logic clk_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic scl_oe_o,
   output logic sda_oe_o
);
   initial begin
      scl_oe_o = 1'b0;
      sda_oe_o = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask : tick
   // release the clock and give way to any stretch by the other side, bounded
   task automatic up();
      int t;
      t = 0;
      scl_oe_o <= 1'b0;
      tick(1);
      while (scl_i !== 1'b1 && t < 3000) begin
         tick(1);
         t++;
      end
   endtask : up
   // data falls while the clock is high
   task automatic start();
      sda_oe_o <= 1'b1;
      tick(3);
      scl_oe_o <= 1'b1;
      tick(3);
   endtask : start
   // data set in the low phase, sampled in the high phase
   task automatic bit_io(input logic b, output logic r);
      sda_oe_o <= ~b;
      tick(3);
      up();
      tick(1);
      r = sda_i;
      scl_oe_o <= 1'b1;
      tick(3);
   endtask : bit_io
   // data rises while the clock is high
   task automatic stop();
      sda_oe_o <= 1'b1;
      tick(3);
      up();
      tick(2);
      sda_oe_o <= 1'b0;
      tick(4);
   endtask : stop
endmodule : wac_far_master
`default_nettype wire
